// file: rbv_rtc_values.sv
// clock/calendar time and alarm value registers behind an apb slave
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
module rbv_rtc_values
    import rbv_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = rbv_pkg::HALF_SEC_CYCLES // half-second period
) (
    input  wire logic        pclk,       // bus clock, 125 MHz
    input  wire logic        presetn,    // async reset, active low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [11:0] paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    input  wire logic [3:0]  pstrb,      // apb byte strobes
    output logic             pready,     // apb ready
    output logic [31:0]      prdata,     // apb read data
    output logic             pslverr,    // apb error
    output logic             half_second // half_second_status level
);
    import rbv_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(HALF_CYCLES - 1); // divider end

    rbv_state_t s_q; // registered state
    rbv_state_t s_d; // next state

    // register map seen from the bus, all words 32 bits, upper half reads zero
    //   control word: run, time_write_enable, half_second_status, time pointer
    //   alarm pointer word: alarm_window_pointer only
    //   time window: entry chosen by time_window_pointer
    //   alarm window: entry chosen by alarm_window_pointer
    // time window entries by pointer value
    //   0: minutes upper byte, seconds lower byte
    //   1: weekday upper byte, hours lower byte
    //   2: month upper byte (read only), day lower byte
    //   3: year lower byte, upper byte unimplemented
    // alarm window entries by pointer value
    //   0: alarm minutes / seconds, always writable
    //   1: alarm weekday / hours, needs time_write_enable
    //   2: alarm month / day, needs time_write_enable
    //   3: unimplemented, reads zero, writes dropped
    // pointer behaviour
    //   steps toward zero on a window read
    //   steps toward zero on a window write with the upper strobe
    //   a lower-byte-only write leaves the pointer in place
    //   blocked writes still step the pointer
    //   the pointer rests at zero, never wraps to three
    // write gating
    //   time_write_enable clear drops every time window write
    //   run bit changes only while the enable is already set
    //   the enable itself has no unlock sequence here
    // read path
    //   read data captured at the setup edge
    //   access phase only completes, no wait states
    //   unmapped addresses answer with an error and read zero
    // counting
    //   half_second_status toggles once per divider period
    //   seconds advance when the second half of a second ends
    //   carries ripple seconds, minutes, hours, day and weekday
    //   day wraps at the length of the current month
    //   leap years when the bcd year is a multiple of four
    //   month wraps twelve to one, year wraps 99 to 00
    // hazards
    //   a bus write in the counting cycle wins over the count
    //   software must read twice to catch a ripple between bytes
    //   out-of-range digits written by software count onward as is
    //   the divider restarts on an accepted seconds write

    // bcd step of a two-digit value, wrapping from last to first
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        logic [7:0] r;
        r = v;
        if (v == last) begin // wrap with carry out
            r = first;
        end else if (v[3:0] == 4'h9) begin // ones digit carries into tens
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_step

    // last day of a bcd month, leap years every fourth bcd year
    function automatic logic [7:0] month_last_day(input logic [7:0] mth, input logic [7:0] yr);
        logic leap;
        logic [7:0] r;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
            || (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        r = 8'h31;
        if (mth == 8'h02) begin // february
            r = leap ? 8'h29 : 8'h28;
        end else if (mth == 8'h04 || mth == 8'h06 || mth == 8'h09 || mth == 8'h11) begin
            r = 8'h30;
        end
        return r;
    endfunction : month_last_day

    // masked merge of a write into a value under byte strobes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [15:0] m, input logic hi,
                                          input logic lo);
        logic [15:0] k;
        k = m & {{8{hi}}, {8{lo}}};
        return (old & ~k) | (wd & k);
    endfunction : merge

    // one pointer step toward zero, stopping there
    function automatic logic [1:0] ptr_down(input logic [1:0] p);
        return (p == 2'h0) ? 2'h0 : p - 2'h1;
    endfunction : ptr_down

    // next-state logic: time base, counting chain, then bus accesses
    always_comb begin
        logic       setup;
        logic       access;
        logic       sec_evt;
        logic [7:0] v;
        logic       alarm_ok;
        logic [7:0] mlast;
        logic [7:0] nx;
        setup    = psel && !penable;
        access   = psel && penable;
        sec_evt  = 1'b0;
        v        = 8'h00;
        alarm_ok = 1'b0;
        mlast    = 8'h00;
        nx       = 8'h00;
        s_d      = s_q;

        // half-second divider, idle while stopped
        if (!s_q.run) begin
            s_d.tick = '0;
        end else if (s_q.tick == TICK_LAST) begin
            s_d.tick = '0;
            s_d.half = !s_q.half;
            sec_evt  = s_q.half; // second ends when second half ends
        end else begin
            s_d.tick = s_q.tick + TICK_W'(1);
        end

        // counting chain with carries kept in bcd range
        // each digit pair wraps to its first value and carries once
        // only the field that wraps passes a carry to the next field
        // the weekday steps together with the day
        if (sec_evt) begin
            v = s_q.tv[IDX_MINUTES_SECONDS_VALUE][7:0];
            s_d.tv[IDX_MINUTES_SECONDS_VALUE][7:0] = bcd_step(v, SEC_LAST, ZERO_FIRST);
            if (v == SEC_LAST) begin // minute carry
                v = s_q.tv[IDX_MINUTES_SECONDS_VALUE][15:8];
                s_d.tv[IDX_MINUTES_SECONDS_VALUE][15:8] = bcd_step(v, MIN_LAST, ZERO_FIRST);
                if (v == MIN_LAST) begin // hour carry
                    v = s_q.tv[IDX_WKHR][7:0];
                    s_d.tv[IDX_WKHR][7:0] = bcd_step(v, HOUR_LAST, ZERO_FIRST);
                    if (v == HOUR_LAST) begin // day carry
                        s_d.tv[IDX_WKHR][10:8] = (s_q.tv[IDX_WKHR][10:8] == WEEKDAY_VALUE_LAST)
                            ? 3'h0 : s_q.tv[IDX_WKHR][10:8] + 3'h1;
                        v     = s_q.tv[IDX_MONTH_DAY_VALUE][7:0];
                        mlast = month_last_day({3'h0, s_q.tv[IDX_MONTH_DAY_VALUE][12:8]},
                                               s_q.tv[IDX_YEAR][7:0]); // month length
                        s_d.tv[IDX_MONTH_DAY_VALUE][7:0] = bcd_step(v, mlast, ONE_FIRST);
                        if (v == mlast) begin // month carry
                            v  = {3'h0, s_q.tv[IDX_MONTH_DAY_VALUE][12:8]};
                            nx = bcd_step(v, MONTH_LAST, ONE_FIRST); // next month
                            s_d.tv[IDX_MONTH_DAY_VALUE][12:8] = nx[4:0];
                            if (v == MONTH_LAST) begin // year carry
                                s_d.tv[IDX_YEAR][7:0] = bcd_step(s_q.tv[IDX_YEAR][7:0],
                                    YEAR_LAST, ZERO_FIRST);
                            end
                        end
                    end
                end
            end
        end

        // setup phase: capture read data and decode result
        if (setup) begin
            s_d.err   = 1'b0;
            s_d.rdata = 32'h0000_0000;
            unique case (paddr)
                CFG_OFFSET: begin // control word, other bits read zero
                    s_d.rdata[RUN_BIT]            = s_q.run;
                    s_d.rdata[WREN_BIT]           = s_q.wren;
                    s_d.rdata[HALF_BIT]           = s_q.half;
                    s_d.rdata[PTR_LSB +: 2]       = s_q.tptr;
                end
                ACFG_OFFSET: begin // alarm pointer word
                    s_d.rdata[PTR_LSB +: 2] = s_q.aptr;
                end
                TWIN_OFFSET: begin // selected time entry, unused bits zero
                    s_d.rdata[15:0] = s_q.tv[s_q.tptr] & TIME_RD_MASK[s_q.tptr];
                end
                AWIN_OFFSET: begin // selected alarm entry, index 3 reads zero
                    s_d.rdata[15:0] = s_q.av[s_q.aptr] & ALARM_RD_MASK[s_q.aptr];
                end
                default: begin // unmapped address
                    s_d.err = 1'b1;
                end
            endcase
        end

        // access phase: writes and pointer steps, taking priority over counting
        if (access && !s_q.err) begin
            unique case (paddr)
                CFG_OFFSET: begin
                    if (pwrite && pstrb[1]) begin
                        s_d.wren = pwdata[WREN_BIT];
                        s_d.tptr = pwdata[PTR_LSB +: 2];
                        if (s_q.wren) begin // enable changes only while unlocked
                            s_d.run = pwdata[RUN_BIT];
                        end
                    end
                end
                ACFG_OFFSET: begin
                    if (pwrite && pstrb[1]) begin
                        s_d.aptr = pwdata[PTR_LSB +: 2];
                    end
                end
                TWIN_OFFSET: begin
                    if (pwrite && s_q.wren) begin
                        s_d.tv[s_q.tptr] = merge(s_q.tv[s_q.tptr], pwdata[15:0],
                            TIME_WR_MASK[s_q.tptr], pstrb[1], pstrb[0]);
                        if (pstrb[0] && s_q.tptr == IDX_MINUTES_SECONDS_VALUE) begin
                            s_d.half = 1'b0;
                            s_d.tick = '0;
                        end
                    end
                    if (!pwrite || pstrb[1]) begin
                        s_d.tptr = ptr_down(s_q.tptr);
                    end
                end
                AWIN_OFFSET: begin
                    alarm_ok = s_q.wren || s_q.aptr == IDX_MINUTES_SECONDS_VALUE;
                    if (pwrite && alarm_ok) begin
                        s_d.av[s_q.aptr] = merge(s_q.av[s_q.aptr], pwdata[15:0],
                            ALARM_RD_MASK[s_q.aptr], pstrb[1], pstrb[0]);
                    end
                    if (!pwrite || pstrb[1]) begin
                        s_d.aptr = ptr_down(s_q.aptr);
                    end
                end
                default: begin // nothing to do
                end
            endcase
        end
    end

    // state register; values cleared for determinism only
    // software must still treat the value fields as unknown after reset
    // the reset branch loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers: zero wait, data from flops
    assign pready      = 1'b1;
    assign prdata      = s_q.rdata;
    assign pslverr     = psel && penable && s_q.err;
    assign half_second = s_q.half;

endmodule : rbv_rtc_values
`default_nettype wire

// file: rbv_pkg.sv
// constants and state types for the clock/calendar value register block
`default_nettype none
package rbv_pkg;
    // apb byte addresses of the four words
    localparam logic [11:0] CFG_OFFSET   = 12'h000; // time control word
    localparam logic [11:0] ACFG_OFFSET  = 12'h004; // alarm pointer word
    localparam logic [11:0] TWIN_OFFSET  = 12'h008; // time value window
    localparam logic [11:0] AWIN_OFFSET  = 12'h00c; // alarm value window
    // control word bit positions
    localparam int RUN_BIT  = 15; // counting enable
    localparam int WREN_BIT = 13; // time_write_enable
    localparam int HALF_BIT = 11; // half_second_status, read only
    localparam int PTR_LSB  = 8;  // window pointer, two bits
    // window pointer indexes
    localparam logic [1:0] IDX_MINUTES_SECONDS_VALUE = 2'h0; // minutes / seconds
    localparam logic [1:0] IDX_WKHR   = 2'h1; // weekday / hours
    localparam logic [1:0] IDX_MONTH_DAY_VALUE  = 2'h2; // month / day
    localparam logic [1:0] IDX_YEAR   = 2'h3; // year, lower byte only
    // implemented bits per window entry, index 3 first
    localparam logic [3:0][15:0] TIME_RD_MASK  = {16'h00ff, 16'h1f3f, 16'h073f, 16'h7f7f};
    localparam logic [3:0][15:0] TIME_WR_MASK  = {16'h00ff, 16'h003f, 16'h073f, 16'h7f7f};
    localparam logic [3:0][15:0] ALARM_RD_MASK = {16'h0000, 16'h1f3f, 16'h073f, 16'h7f7f};
    // bcd limits of the counting chain
    localparam logic [7:0] SEC_LAST   = 8'h59;
    localparam logic [7:0] MIN_LAST   = 8'h59;
    localparam logic [7:0] HOUR_LAST  = 8'h23;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST  = 8'h99;
    localparam logic [7:0] ZERO_FIRST = 8'h00;
    localparam logic [7:0] ONE_FIRST  = 8'h01;
    localparam logic [2:0] WEEKDAY_VALUE_LAST  = 3'h6;
    // half-second time base
    localparam int CLK_MHZ         = 125;
    localparam int HALF_SEC_MS     = 500;
    localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1000 * CLK_MHZ;
    localparam int TICK_W          = 26;
    // whole state of the block
    typedef struct packed {
        logic [3:0][15:0] tv;    // time values, by pointer index
        logic [3:0][15:0] av;    // alarm values, index 3 unimplemented
        logic             run;   // counting enable
        logic             wren;  // time_write_enable
        logic             half;  // half_second_status
        logic [1:0]       tptr;  // time_window_pointer
        logic [1:0]       aptr;  // alarm_window_pointer
        logic [TICK_W-1:0] tick; // half-second divider
        logic [31:0]      rdata; // read data captured in setup
        logic             err;   // unmapped address seen in setup
    } rbv_state_t;
endpackage : rbv_pkg
`default_nettype wire

// file: rbv_rtc_values_chk.sv
// assertions on the ports of the value register block
`default_nettype none
module rbv_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        half_second
);
    // one domain, async reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb phases
    sequence acc_s; psel && penable; endsequence
    sequence bad_s; psel && !penable && paddr > 12'h00c; endsequence
    sequence win_s; acc_s ##0 (!pwrite && paddr inside {12'h008, 12'h00c}); endsequence
    ready_on_a: assert property (pready)
        else $error("ready low");
    bad_addr_a: assert property (bad_s ##1 acc_s |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    ok_addr_a: assert property (psel && penable && paddr <= 12'h00c |-> !pslverr)
        else $error("mapped refused");
    err_when_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    upper_zero_a: assert property (acc_s |-> prdata[31:16] == 16'h0)
        else $error("upper half not zero");
    win_gap_a: assert property (win_s |-> !prdata[15] && !prdata[7])
        else $error("gap bit set");
    rd_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved");
    reset_zero_a: assert property ($rose(presetn) |-> prdata == 32'h0 && !half_second)
        else $error("not quiet after reset");
endmodule : rbv_chk
bind rbv_rtc_values rbv_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .half_second(half_second)
);
`default_nettype wire

// file: test_rbv_rtc_values.sv
// self-checking bench for the value register block
`default_nettype none
module test_rbv_rtc_values;
    timeunit 1ns;
    timeprecision 1ps;
    import rbv_pkg::*;
    `define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
        $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
    logic        pclk = 1'b0;   // bus clock
    logic        presetn = 1'b1; // reset, active low, pulled at time zero
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [3:0]  pstrb = 4'h0;
    logic        rerr;          // last error response
    wire logic   pready, pslverr, half_second;
    wire logic [31:0] prdata;
    int          n_mismatch = 0, checks = 0;
    // 125 MHz
    always #4 pclk = ~pclk;
    rbv_rtc_values #(.HALF_CYCLES(4)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .half_second(half_second)
    );
    // one apb transfer, held until ready
    task xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= 4'h3;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // read and compare
    task rd(input logic [11:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0);
        `CHK(rdat, {16'h0, e})
    endtask : rd
    // wait for a half-second level
    task wait_half(input logic v);
        int n;
        n = 0;
        while (half_second !== v && n < 100) begin @(negedge pclk); n++; end
        `CHK(half_second, v)
    endtask : wait_half
    // field layout, masking, month read only
    task t_fields;
        xfer(1, CFG_OFFSET, 16'h2300);
        xfer(1, TWIN_OFFSET, 16'hff42);
        xfer(1, TWIN_OFFSET, 16'h1225);
        xfer(1, TWIN_OFFSET, 16'hfe23);
        xfer(1, TWIN_OFFSET, 16'hd959);
        xfer(1, CFG_OFFSET, 16'h2300);
        rd(TWIN_OFFSET, 16'h0042);
        rd(TWIN_OFFSET, 16'h0025);
        rd(TWIN_OFFSET, 16'h0623);
        rd(TWIN_OFFSET, 16'h5959);
        rd(TWIN_OFFSET, 16'h5959);
        $display("fields done");
    endtask : t_fields
    // writes blocked while enable clear
    task t_lock;
        xfer(1, CFG_OFFSET, 16'h0300);
        repeat (4) xfer(1, TWIN_OFFSET, 16'h0000);
        xfer(1, CFG_OFFSET, 16'h0300);
        rd(TWIN_OFFSET, 16'h0042);
        rd(TWIN_OFFSET, 16'h0025);
        rd(TWIN_OFFSET, 16'h0623);
        rd(TWIN_OFFSET, 16'h5959);
        $display("lock done");
    endtask : t_lock
    // alarm window layout and gating
    task t_alarm;
        xfer(1, CFG_OFFSET, 16'h2000);
        xfer(1, ACFG_OFFSET, 16'h0200);
        repeat (3) xfer(1, AWIN_OFFSET, 16'hffff);
        xfer(1, ACFG_OFFSET, 16'h0300);
        rd(AWIN_OFFSET, 16'h0000);
        rd(AWIN_OFFSET, 16'h1f3f);
        rd(AWIN_OFFSET, 16'h073f);
        rd(AWIN_OFFSET, 16'h7f7f);
        xfer(1, CFG_OFFSET, 16'h0000);
        xfer(1, ACFG_OFFSET, 16'h0200);
        repeat (3) xfer(1, AWIN_OFFSET, 16'h0000);
        xfer(1, ACFG_OFFSET, 16'h0200);
        rd(AWIN_OFFSET, 16'h1f3f);
        rd(AWIN_OFFSET, 16'h073f);
        rd(AWIN_OFFSET, 16'h0000);
        $display("alarm done");
    endtask : t_alarm
    // unmapped address refused
    task t_unmapped;
        xfer(1, 12'h010, 16'hffff);
        `CHK(rerr, 1'b1)
        rd(12'h010, 16'h0000);
        `CHK(rerr, 1'b1)
        $display("unmapped done");
    endtask : t_unmapped
    // half-second clear and midnight carry
    task t_count;
        xfer(1, CFG_OFFSET, 16'h2000);
        xfer(1, CFG_OFFSET, 16'ha100);
        xfer(1, TWIN_OFFSET, 16'h0623);
        wait_half(1'b1);
        xfer(1, TWIN_OFFSET, 16'h5959);
        #1 `CHK(half_second, 1'b0)
        wait_half(1'b1);
        wait_half(1'b0);
        xfer(1, CFG_OFFSET, 16'h2100);
        rd(TWIN_OFFSET, 16'h0000);
        rd(TWIN_OFFSET, 16'h0000);
        $display("count done");
    endtask : t_count
    // verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_fields;
        t_lock;
        t_alarm;
        t_unmapped;
        t_count;
        report_and_stop;
    end
    // hang guard
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end
endmodule : test_rbv_rtc_values
`default_nettype wire
